// >>> verilog/wdlp_top.sv
// watchdog and low-power mode control with axi4-lite registers
// What this block does
// - 8-bit counter fires reset at maximum
// - key 0x55 then 0xAA clears counter
// - disabled watchdog never pulses reset
// - reset pulse lasts exactly 512 clocks
// - watchdog interrupt serves as wake timer
// - standby keeps watchdog running and waking
// - idle: watchdog interrupt reaches cpu
// - halt stops watchdog counting and events
// - select 00 idle, 01 standby, 1x halt
// - clock gating in standby and halt; idle keeps all clocks on
// - idle exits on reset, watchdog, irq, nmi
// - standby wakes on reset, debug request or selected sources
// - standby wakes qualified for programmed clocks
// - halt exits only on reset, nmi or debug request
// - wake must stay low until recognised
// - nmi to core has enable bit
// - low-power modes leave pins unchanged
// - debugger request exits any mode
`timescale 1ns/1ns
`include "wdlp_params.svh"
module wdlp_top #(
    parameter int ADDR_W = 5
) (
    // clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    // axi4-lite write
    input  wire logic              awvalid_in,
    output logic                   awready_out,
    input  wire logic [ADDR_W-1:0] awaddr_in,
    input  wire logic              wvalid_in,
    output logic                   wready_out,
    input  wire logic [31:0]       wdata_in,
    input  wire logic [3:0]        wstrb_in,
    output logic                   bvalid_out,
    input  wire logic              bready_in,
    output logic      [1:0]        bresp_out,
    // axi4-lite read
    input  wire logic              arvalid_in,
    output logic                   arready_out,
    input  wire logic [ADDR_W-1:0] araddr_in,
    output logic                   rvalid_out,
    input  wire logic              rready_in,
    output logic      [31:0]       rdata_out,
    output logic      [1:0]        rresp_out,
    // cpu side
    input  wire logic              idle_exec_in,
    input  wire logic              enabled_irq_in,
    output logic                   cpu_resume_out,
    output logic                   nmi_to_core_out,
    // wake pins, active low
    input  wire logic              ext_reset_n_in,
    input  wire logic              ext_nmi_n_in,
    input  wire logic              external_irq_one_n_in,
    input  wire logic              debug_req_n_in,
    // outputs
    output logic                   watchdog_reset_n_out,
    output logic                   watchdog_wake_irq_out,
    output wdlp_pkg::wdlp_clk_s    clk_gate_out,
    output logic                   pin_hold_out,
    output logic                   irq_out
);
    import wdlp_pkg::*;

    if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
        $error("address width must be 5 to 32");
    end

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && ((a >> 5) == '0);
    endfunction : is_mapped

    function automatic wdlp_clk_s gate_of(input wdlp_state_e s);
        wdlp_clk_s g;
        g.osc_clock    = (s != ST_HALT);
        g.core_clock   = (s == ST_RUN) || (s == ST_WAKE) || (s == ST_IDLE);
        g.system_clock = g.core_clock;
        return g;
    endfunction : gate_of

    function automatic wdlp_state_e lp_target(input logic [1:0] sel);
        if (sel[1]) begin
            return ST_HALT;
        end else if (sel[0]) begin
            return ST_STBY;
        end
        return ST_IDLE;
    endfunction : lp_target

    // registers
    logic [1:0]        lpsel_q;
    logic [7:0]        qual_q;
    logic [2:0]        wakesel_q;
    logic [1:0]        wdctrl_q;
    logic [1:0]        sts_q;
    logic [1:0]        mask_q;
    // bus state
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              do_write;
    logic              rd_take;
    logic [31:0]       rd_word;
    // pins, mode and watchdog
    logic [3:0]        sync1_q;
    logic [3:0]        sync2_q;
    logic [3:0]        pin_low;
    wdlp_state_e       state_q;
    wdlp_state_e       state_d;
    logic [7:0]        qual_cnt_q;
    logic [7:0]        qual_len;
    logic              sel_low;
    logic              qual_ok;
    logic              hard_wake;
    logic              nmi_ok;
    logic [7:0]        wd_count;
    logic              wd_evt;
    logic              wd_key_we;
    logic              wd_rst_n;

    // write channel: one write in flight, aw and w in either order
    assign do_write = aw_hold_q && w_hold_q && !bvalid_out;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            awready_out <= 1'b1;
            wready_out  <= 1'b1;
            aw_hold_q   <= 1'b0;
            w_hold_q    <= 1'b0;
            aw_addr_q   <= '0;
            w_data_q    <= 32'h0000_0000;
            w_strb_q    <= 4'h0;
            bvalid_out  <= 1'b0;
            bresp_out   <= `WDLP_RESP_OKAY;
        end else begin
            if (awvalid_in && awready_out) begin
                aw_hold_q   <= 1'b1;
                awready_out <= 1'b0;
                aw_addr_q   <= awaddr_in;
            end
            if (wvalid_in && wready_out) begin
                w_hold_q   <= 1'b1;
                wready_out <= 1'b0;
                w_data_q   <= wdata_in;
                w_strb_q   <= wstrb_in;
            end
            if (do_write) begin
                aw_hold_q  <= 1'b0;
                w_hold_q   <= 1'b0;
                bvalid_out <= 1'b1;
                bresp_out  <= is_mapped(aw_addr_q) ? `WDLP_RESP_OKAY
                                                   : `WDLP_RESP_SLVERR;
            end
            if (bvalid_out && bready_in) begin
                bvalid_out  <= 1'b0;
                awready_out <= 1'b1;
                wready_out  <= 1'b1;
            end
        end
    end

    // control registers, byte lanes 0 and 1 only
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lpsel_q   <= `WDLP_LPSEL_RST;
            qual_q    <= `WDLP_QUAL_RST;
            wakesel_q <= `WDLP_WAKESEL_RST;
            wdctrl_q  <= `WDLP_WDCTRL_RST;
            mask_q    <= `WDLP_MASK_RST;
        end else if (do_write && is_mapped(aw_addr_q)) begin
            unique case (aw_addr_q[4:0])
                `WDLP_OFF_LPCTRL0: begin
                    if (w_strb_q[0]) begin
                        lpsel_q <= w_data_q[`WDLP_LPSEL_LSB +: 2];
                    end
                    if (w_strb_q[1]) begin
                        qual_q <= w_data_q[`WDLP_QUAL_LSB +: 8];
                    end
                end
                `WDLP_OFF_WAKESEL: begin
                    if (w_strb_q[0]) begin
                        wakesel_q <= w_data_q[2:0];
                    end
                end
                `WDLP_OFF_WDCTRL: begin
                    if (w_strb_q[0]) begin
                        wdctrl_q <= w_data_q[1:0];
                    end
                end
                `WDLP_OFF_MASK: begin
                    if (w_strb_q[0]) begin
                        mask_q <= w_data_q[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign wd_key_we = do_write && w_strb_q[0] && is_mapped(aw_addr_q)
                       && (aw_addr_q[4:0] == `WDLP_OFF_WDKEY);

    // read channel
    assign rd_take = arvalid_in && arready_out;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (araddr_in[4:0])
            `WDLP_OFF_LPCTRL0: begin
                rd_word[`WDLP_LPSEL_LSB +: 2] = lpsel_q;
                rd_word[`WDLP_QUAL_LSB +: 8]  = qual_q;
            end
            `WDLP_OFF_WAKESEL: rd_word[2:0] = wakesel_q;
            `WDLP_OFF_WDCTRL:  rd_word[1:0] = wdctrl_q;
            `WDLP_OFF_WDCOUNT: rd_word[7:0] = wd_count;
            `WDLP_OFF_STATUS:  rd_word[1:0] = sts_q;
            `WDLP_OFF_MASK:    rd_word[1:0] = mask_q;
            `WDLP_OFF_MODE:    rd_word[4:0] = state_q;
            default:           rd_word      = 32'h0000_0000;
        endcase
        if (!is_mapped(araddr_in)) begin
            rd_word = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            arready_out <= 1'b1;
            rvalid_out  <= 1'b0;
            rdata_out   <= 32'h0000_0000;
            rresp_out   <= `WDLP_RESP_OKAY;
        end else begin
            if (rd_take) begin
                arready_out <= 1'b0;
                rvalid_out  <= 1'b1;
                rdata_out   <= rd_word;
                rresp_out   <= is_mapped(araddr_in) ? `WDLP_RESP_OKAY
                                                    : `WDLP_RESP_SLVERR;
            end
            if (rvalid_out && rready_in) begin
                rvalid_out  <= 1'b0;
                arready_out <= 1'b1;
            end
        end
    end

    // sticky status, cleared by read; a new event wins over the clear
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sts_q   <= 2'h0;
            irq_out <= 1'b0;
        end else begin
            sts_q <= ((rd_take && is_mapped(araddr_in)
                       && araddr_in[4:0] == `WDLP_OFF_STATUS) ? 2'h0 : sts_q)
                     | {(state_q == ST_WAKE), wd_evt};
            irq_out <= |(sts_q & mask_q);
        end
    end

    // pins are asynchronous: two flops, reset to inactive high
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
        end else begin
            sync1_q <= {debug_req_n_in, external_irq_one_n_in,
                        ext_nmi_n_in, ext_reset_n_in};
            sync2_q <= sync1_q;
        end
    end
    assign pin_low = ~sync2_q;

    wdlp_wdog #(
        .CNT_W       (8)
    ) u_wdog (
        .clk_in      (mclk_in),
        .rst_in      (rst_in),
        .run_in      (state_q != ST_HALT),
        .disable_in  (wdctrl_q[`WDLP_WD_DIS_BIT]),
        .key_we_in   (wd_key_we),
        .key_data_in (w_data_q[7:0]),
        .count_out   (wd_count),
        .event_out   (wd_evt),
        .reset_n_out (wd_rst_n)
    );

    assign hard_wake = pin_low[0] || pin_low[3];
    assign nmi_ok    = pin_low[1] && wdctrl_q[`WDLP_NMI_EN_BIT];
    assign sel_low   = |(wakesel_q & {pin_low[1], pin_low[2],
                                      sts_q[`WDLP_STS_WD_BIT]});
    assign qual_len  = (qual_q == 8'h00) ? 8'h01 : qual_q;
    assign qual_ok   = sel_low
                       && ({1'b0, qual_cnt_q} + 9'h001 >= {1'b0, qual_len});

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            qual_cnt_q <= 8'h00;
        end else if (state_q == ST_STBY && sel_low) begin
            qual_cnt_q <= (qual_cnt_q == 8'hFF) ? qual_cnt_q
                                                : qual_cnt_q + 8'h01;
        end else begin
            qual_cnt_q <= 8'h00;
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (idle_exec_in) begin
                    state_d = lp_target(lpsel_q);
                end
            end
            ST_IDLE: begin
                if (hard_wake || wd_evt || enabled_irq_in || nmi_ok) begin
                    state_d = ST_WAKE;
                end
            end
            ST_STBY: begin
                if (hard_wake || qual_ok) begin
                    state_d = ST_WAKE;
                end
            end
            ST_HALT: begin
                if (hard_wake || pin_low[1]) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q               <= ST_RUN;
            clk_gate_out          <= 3'h7;
            pin_hold_out          <= 1'b0;
            cpu_resume_out        <= 1'b0;
            nmi_to_core_out       <= 1'b0;
            watchdog_wake_irq_out <= 1'b0;
            watchdog_reset_n_out  <= 1'b1;
        end else begin
            state_q               <= state_d;
            clk_gate_out          <= gate_of(state_d);
            pin_hold_out          <= (state_d != ST_RUN)
                                     && (state_d != ST_WAKE);
            cpu_resume_out        <= (state_q == ST_WAKE);
            nmi_to_core_out       <= nmi_ok;
            watchdog_wake_irq_out <= wd_evt;
            watchdog_reset_n_out  <= wd_rst_n;
        end
    end

    property p_halt_still;
        @(posedge mclk_in) disable iff (rst_in)
        (state_q == ST_HALT && $past(state_q) == ST_HALT)
            |-> $stable(wd_count) && !wd_evt;
    endproperty
    a_halt_still: assert property (p_halt_still)
        else $error("watchdog active in halt");

    property p_stby_gate;
        @(posedge mclk_in) disable iff (rst_in)
        (state_q == ST_STBY) |-> clk_gate_out == 3'h4;
    endproperty
    a_stby_gate: assert property (p_stby_gate)
        else $error("standby clock gating wrong");

    property p_halt_gate;
        @(posedge mclk_in) disable iff (rst_in)
        (state_q == ST_HALT) |-> clk_gate_out == 3'h0;
    endproperty
    a_halt_gate: assert property (p_halt_gate)
        else $error("halt clock gating wrong");

    property p_halt_exit;
        @(posedge mclk_in) disable iff (rst_in)
        (state_q == ST_HALT && sync2_q == 4'hF) |=> (state_q == ST_HALT);
    endproperty
    a_halt_exit: assert property (p_halt_exit)
        else $error("halt left without reset or nmi");

    property p_stby_hold;
        @(posedge mclk_in) disable iff (rst_in)
        (state_q == ST_STBY && !hard_wake && !sel_low)
            |=> (state_q == ST_STBY);
    endproperty
    a_stby_hold: assert property (p_stby_hold)
        else $error("standby left without held wake");

    property p_stby_qual;
        @(posedge mclk_in) disable iff (rst_in)
        (state_q == ST_STBY && !hard_wake && qual_ok)
            |=> (state_q == ST_WAKE) ##1 (cpu_resume_out && state_q == ST_RUN);
    endproperty
    a_stby_qual: assert property (p_stby_qual)
        else $error("qualified wake not taken");

    property p_idle_wd;
        @(posedge mclk_in) disable iff (rst_in)
        (state_q == ST_IDLE && wd_evt) |=> (state_q == ST_WAKE);
    endproperty
    a_idle_wd: assert property (p_idle_wd)
        else $error("watchdog did not end idle");

    property p_nmi_gate;
        @(posedge mclk_in) disable iff (rst_in)
        !wdctrl_q[`WDLP_NMI_EN_BIT] |=> !nmi_to_core_out;
    endproperty
    a_nmi_gate: assert property (p_nmi_gate)
        else $error("nmi passed while disabled");
endmodule : wdlp_top

// >>> verilog/wdlp_params.svh
// offsets, field positions, reset values and timing counts
`ifndef WDLP_PARAMS_SVH
`define WDLP_PARAMS_SVH
// register byte offsets
`define WDLP_OFF_LPCTRL0   5'h00
`define WDLP_OFF_WAKESEL   5'h04
`define WDLP_OFF_WDCTRL    5'h08
`define WDLP_OFF_WDCOUNT   5'h0C
`define WDLP_OFF_WDKEY     5'h10
`define WDLP_OFF_STATUS    5'h14
`define WDLP_OFF_MASK      5'h18
`define WDLP_OFF_MODE      5'h1C
// field positions
`define WDLP_LPSEL_LSB     0
`define WDLP_QUAL_LSB      8
`define WDLP_WD_DIS_BIT    0
`define WDLP_NMI_EN_BIT    1
`define WDLP_STS_WD_BIT    0
`define WDLP_STS_WAKE_BIT  1
`define WDLP_WSEL_WD_BIT   0
`define WDLP_WSEL_IRQ1_BIT 1
`define WDLP_WSEL_NMI_BIT  2
// reset values
`define WDLP_LPSEL_RST     2'h0
`define WDLP_QUAL_RST      8'h01
`define WDLP_WAKESEL_RST   3'h0
`define WDLP_WDCTRL_RST    2'h0
`define WDLP_MASK_RST      2'h0
// service key values
`define WDLP_KEY_ARM       8'h55
`define WDLP_KEY_SERVE     8'hAA
// reset pulse width, 512 osc clocks
`define WDLP_RST_PULSE_CYC 10'h200
`define WDLP_RST_PULSE_LEN 11'h200
// axi responses
`define WDLP_RESP_OKAY     2'h0
`define WDLP_RESP_SLVERR   2'h2
`endif

// >>> verilog/wdlp_pkg.sv
// types shared by the watchdog and low-power blocks
package wdlp_pkg;
    typedef enum logic [4:0] {
        ST_RUN  = 5'h01,
        ST_IDLE = 5'h02,
        ST_STBY = 5'h04,
        ST_HALT = 5'h08,
        ST_WAKE = 5'h10
    } wdlp_state_e;

    typedef struct packed {
        logic osc_clock;
        logic core_clock;
        logic system_clock;
    } wdlp_clk_s;
endpackage : wdlp_pkg

// >>> verilog/wdlp_wdog.sv
// 8-bit watchdog counter, key service and reset pulse
`timescale 1ns/1ns
`include "wdlp_params.svh"
module wdlp_wdog #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // control
    input  wire logic             run_in,
    input  wire logic             disable_in,
    input  wire logic             key_we_in,
    input  wire logic [7:0]       key_data_in,
    // status and outputs
    output logic      [CNT_W-1:0] count_out,
    output logic                  event_out,
    output logic                  reset_n_out
);
    import wdlp_pkg::*;

    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    logic [9:0]  pulse_q;
    logic        armed_q;
    logic [10:0] low_len_q;
    logic        fire;
    logic        key_ok;

    if (CNT_W < 2) begin : g_chk
        $error("watchdog counter too narrow");
    end

    // disable blocks firing
    // no new fire while a pulse runs, so the pulse is never stretched
    assign fire   = run_in && !disable_in && (pulse_q == 10'h000)
                    && (count_out == CNT_MAX);
    assign key_ok = key_we_in && armed_q
                    && (key_data_in == `WDLP_KEY_SERVE);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            armed_q <= 1'b0;
        end else if (key_we_in) begin
            armed_q <= (key_data_in == `WDLP_KEY_ARM);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= '0;
        end else if (key_ok || fire || (pulse_q != 10'h000)) begin
            count_out <= '0;
        end else if (run_in && !disable_in) begin
            count_out <= count_out + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pulse_q     <= 10'h000;
            reset_n_out <= 1'b1;
            event_out   <= 1'b0;
        end else begin
            if (fire) begin
                pulse_q <= `WDLP_RST_PULSE_CYC;
            end else if (pulse_q != 10'h000) begin
                pulse_q <= pulse_q - 10'h001;
            end
            reset_n_out <= !(fire || (pulse_q > 10'h001));
            event_out   <= fire;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            low_len_q <= 11'h000;
        end else if (!reset_n_out) begin
            low_len_q <= low_len_q + 11'h001;
        end else begin
            low_len_q <= 11'h000;
        end
    end

    property p_fire;
        @(posedge clk_in) disable iff (rst_in)
        fire |=> (!reset_n_out && event_out) ##1 (!reset_n_out [*8]);
    endproperty
    a_fire: assert property (p_fire)
        else $error("no reset pulse at maximum count");

    property p_key;
        @(posedge clk_in) disable iff (rst_in)
        (key_we_in && armed_q && key_data_in == `WDLP_KEY_SERVE)
            |=> (count_out == '0);
    endproperty
    a_key: assert property (p_key)
        else $error("key sequence did not clear counter");

    property p_off;
        @(posedge clk_in) disable iff (rst_in)
        (disable_in && reset_n_out) |=> reset_n_out;
    endproperty
    a_off: assert property (p_off)
        else $error("reset pulse while disabled");

    property p_len;
        @(posedge clk_in) disable iff (rst_in)
        $rose(reset_n_out) |-> (low_len_q == `WDLP_RST_PULSE_LEN);
    endproperty
    a_len: assert property (p_len)
        else $error("reset pulse not 512 cycles");
endmodule : wdlp_wdog

// >>> dv/wdlp_far_model.sv
// cpu core and wake pin model on the far side of the block
`timescale 1ns/1ns
module wdlp_far_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // requests from the bench: {nmi, irq one, enabled irq}
    input  wire logic       go_idle_in,
    input  wire logic [2:0] wake_req_in,
    input  wire logic       resume_in,
    // pins towards the block
    output logic            idle_exec_out,
    output logic            enabled_irq_out,
    output logic            ext_nmi_n_out,
    output logic            irq_one_n_out
);
    logic [2:0] hold_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            idle_exec_out <= 1'b0;
            hold_q        <= 3'h0;
        end else begin
            idle_exec_out <= go_idle_in;
            hold_q <= resume_in ? 3'h0 : (hold_q | wake_req_in);
        end
    end
    assign enabled_irq_out = hold_q[0];
    assign irq_one_n_out   = ~hold_q[1];
    assign ext_nmi_n_out   = ~hold_q[2];
endmodule : wdlp_far_model

// >>> dv/tb_top.sv
// self-checking bench for the watchdog and low-power block
`timescale 1ns/1ns
`include "wdlp_params.svh"
module tb_top;
    import wdlp_pkg::*;
    logic        clk, rst, awv, wv, bre, arv, rre, go, idle_x, en_irq;
    logic        nmi_n, irq1_n, aw_rdy, w_rdy, bv, ar_rdy, rv, resume;
    logic        nmi_core, wdr_n, wd_irq, hold, irq, dbg_n;
    logic [1:0]  br, rr;
    logic [2:0]  req;
    logic [4:0]  awa, ara;
    logic [31:0] wd, rd, rdat;
    wdlp_clk_s   gate;
    int          err_count, comparisons, cyc, n;
    logic [15:0] lp [3] = '{16'h0100, 16'h0301, 16'h0102};
    logic [2:0]  ws [3] = '{3'h0, 3'h2, 3'h0};
    logic [2:0]  gt [3] = '{3'h7, 3'h4, 3'h0};
    logic [2:0]  rq [3] = '{3'h1, 3'h2, 3'h4};
    logic [4:0]  md [3] = '{5'h02, 5'h04, 5'h08};

    wdlp_top uut (.mclk_in(clk), .rst_in(rst), .awvalid_in(awv),
        .awready_out(aw_rdy), .awaddr_in(awa), .wvalid_in(wv),
        .wready_out(w_rdy), .wdata_in(wd), .wstrb_in(4'hF),
        .bvalid_out(bv), .bready_in(bre), .bresp_out(br),
        .arvalid_in(arv), .arready_out(ar_rdy), .araddr_in(ara),
        .rvalid_out(rv), .rready_in(rre), .rdata_out(rd), .rresp_out(rr),
        .idle_exec_in(idle_x), .enabled_irq_in(en_irq),
        .cpu_resume_out(resume), .nmi_to_core_out(nmi_core),
        .ext_reset_n_in(1'b1), .ext_nmi_n_in(nmi_n),
        .external_irq_one_n_in(irq1_n), .debug_req_n_in(dbg_n),
        .watchdog_reset_n_out(wdr_n), .watchdog_wake_irq_out(wd_irq),
        .clk_gate_out(gate), .pin_hold_out(hold), .irq_out(irq));
    wdlp_far_model far (.clk_in(clk), .rst_in(rst), .go_idle_in(go),
        .wake_req_in(req), .resume_in(resume), .idle_exec_out(idle_x),
        .enabled_irq_out(en_irq), .ext_nmi_n_out(nmi_n),
        .irq_one_n_out(irq1_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task wrap_up;
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    // hang guard, the whole run needs about 1500 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            wrap_up;
        end
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; bre <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_rdy) awv <= 1'b0;
            if (w_rdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
    endtask : wr
    task rdr(input logic [4:0] a);
        @(posedge clk);
        arv <= 1'b1; ara <= a; rre <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_rdy) arv <= 1'b0;
        end while (rv !== 1'b1);
        rdat = rd;
        rre <= 1'b0;
    endtask : rdr
    task t_reset;
        rdr(`WDLP_OFF_LPCTRL0);
        chk("lpctrl0", 16'h0100, rdat[15:0]);
        rdr(`WDLP_OFF_MODE);
        chk("mode", 16'h0001, rdat[15:0]);
        chk("gate", 16'h0007, {13'h0, gate});
        rdr(5'h02);
        chk("misaligned", 16'h0002, {14'h0, rr});
    endtask : t_reset
    task t_fire;
        n = 0;
        while (wdr_n !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("wake_irq", 16'h0001, {15'h0, wd_irq});
        n = 0;
        while (wdr_n === 1'b0 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk("pulse_len", 16'h0200, n[15:0]);
        chk("irq_masked", 16'h0000, {15'h0, irq});
        wr(`WDLP_OFF_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("irq_set", 16'h0001, {15'h0, irq});
        rdr(`WDLP_OFF_STATUS);
        chk("status", 16'h0001, rdat[15:0]);
        repeat (2) @(posedge clk);
        chk("irq_clr", 16'h0000, {15'h0, irq});
        rdr(`WDLP_OFF_STATUS);
        chk("status_clr", 16'h0000, rdat[15:0]);
    endtask : t_fire
    task t_key_dis;
        // service sequence from the software side
        wr(`WDLP_OFF_WDKEY, 32'h0000_0055);
        wr(`WDLP_OFF_WDKEY, 32'h0000_00AA);
        rdr(`WDLP_OFF_WDCOUNT);
        chk("count_low", 16'h0001, {15'h0, rdat < 32'h0000_0010});
        wr(`WDLP_OFF_WDCTRL, 32'h0000_0001);
        n = 0;
        repeat (600) @(posedge clk) if (wdr_n !== 1'b1) n++;
        chk("no_fire", 16'h0000, n[15:0]);
    endtask : t_key_dis
    task t_modes;
        for (int i = 0; i < 3; i++) begin
            wr(`WDLP_OFF_LPCTRL0, {16'h0, lp[i]});
            // irq one chosen as the standby step's source; the idle and halt steps choose none
            wr(`WDLP_OFF_WAKESEL, {29'h0, ws[i]});
            go <= 1'b1;
            @(posedge clk) go <= 1'b0;
            repeat (5) @(posedge clk);
            chk("lp_gate", {13'h0, gt[i]}, {13'h0, gate});
            chk("pin_hold", 16'h0001, {15'h0, hold});
            rdr(`WDLP_OFF_MODE);
            chk("lp_mode", {11'h0, md[i]}, rdat[15:0]);
            req <= rq[i];
            @(posedge clk) req <= 3'h0;
            n = 0;
            while (resume !== 1'b1 && n < 40) begin
                @(posedge clk);
                n++;
            end
            chk("resume", 16'h0001, {15'h0, resume});
            chk("nmi_core", 16'h0000, {15'h0, nmi_core});
            repeat (2) @(posedge clk);
            chk("run_gate", 16'h0007, {13'h0, gate});
        end
    endtask : t_modes
    task t_debug;
        // halt is still selected from the last mode step
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (5) @(posedge clk);
        chk("dbg_halt", 16'h0000, {13'h0, gate});
        dbg_n <= 1'b0;
        n = 0;
        while (resume !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        dbg_n <= 1'b1;
        chk("dbg_wake", 16'h0001, {15'h0, resume});
    endtask : t_debug
    initial begin
        err_count = 0;
        comparisons = 0;
        cyc = 0;
        rst = 1'b1;
        {awv, wv, bre, arv, rre, go} = 6'h00;
        dbg_n = 1'b1;
        {awa, ara, wd, req} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_fire;
        t_key_dis;
        t_modes;
        t_debug;
        wrap_up;
    end
endmodule : tb_top
